// >>> hw/i2cm_baud.sv
`include "i2cm_defs.svh"

module i2cm_baud (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       load,
  input  wire logic [6:0] reload,
  output logic            timeout
);

  logic [1:0] phase_reg;
  logic [6:0] cnt_reg;
  logic       active_reg;
  logic       timeout_reg;
  logic       tick;

  // two ticks per four-clock instruction cycle
  assign tick = (phase_reg == `I2CM_PHASE_Q2) || (phase_reg == `I2CM_PHASE_Q4); // R22
  assign timeout = timeout_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg     <= 7'h00;
      active_reg  <= 1'b0;
      timeout_reg <= 1'b0;
    end else begin
      timeout_reg <= 1'b0;
      if (load) begin
        cnt_reg    <= reload; // R21
        active_reg <= 1'b1;
      end else if (active_reg && tick) begin
        if (cnt_reg == 7'h00) begin
          active_reg  <= 1'b0; // R21
          timeout_reg <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - 7'h01;
        end
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_tick_spacing: assert property (tick |=> !tick) // R22
    else $error("baud tick on two adjacent clocks");
  a_count_stops: assert property (!active_reg && !load |=> cnt_reg == $past(cnt_reg) && !timeout_reg) // R21
    else $error("baud counter moved while stopped");

endmodule

// >>> hw/i2cm_defs.svh
`ifndef I2CM_DEFS_SVH
`define I2CM_DEFS_SVH

`define I2CM_AW          6
`define I2CM_OFF_BUF     4'h0
`define I2CM_OFF_CTL     4'h4
`define I2CM_OFF_STAT    4'h8
`define I2CM_OFF_BAUD    4'hc

`define I2CM_CTL_PEN     0
`define I2CM_CTL_RECEIVE_ENABLE_BIT    3
`define I2CM_CTL_ACK_SEQUENCE_ENABLE   4
`define I2CM_CTL_ACK_DATA_BIT   5

`define I2CM_ST_BF       0
`define I2CM_ST_STOP     1
`define I2CM_ST_ACKST    2
`define I2CM_ST_WRITE_COLLISION_FLAG     3
`define I2CM_ST_OVF      4
`define I2CM_ST_IRQ      5

`define I2CM_BAUD_RST    7'h09
`define I2CM_RESP_OKAY   2'h0
`define I2CM_RESP_SLVERR 2'h2

`define I2CM_PHASE_Q2    2'h1
`define I2CM_PHASE_Q4    2'h3
`define I2CM_BIT_LAST    4'h7
`define I2CM_BIT_ACK     4'h8

`endif

// >>> hw/i2cm_engine.sv
// Behaviour
// R1 - buffer write sets buffer full, starts baud counter, begins shifting byte out
// R2 - transmit: SDA changes after SCL falls; SCL low one period, high one period
// R3 - after eighth bit fall: clear buffer full, release SDA for slave acknowledge
// R4 - ninth clock fall samples SDA: ack status cleared on low, set on high
// R5 - after ninth clock: set interrupt flag, stop counter, SCL low, SDA released
// R6 - address byte goes out seven bits then R/W, MSB first
// R7 - buffer write during transmit sets write collision, buffer unchanged; software clears
// R8 - buffer write during receive, acknowledge or stop also collides and is dropped
// R9 - receive enable set is ignored unless engine idle
// R10 - receive: SCL toggles per counter rollover, SDA shifted in each clock
// R11 - eighth receive fall: clear enable, load buffer, set full and interrupt, idle
// R12 - reading the buffer after reception clears buffer full
// R13 - eight more bits while buffer still full set receive overflow
// R14 - acknowledge: SCL low, ack data on SDA, one period, release SCL
// R15 - SCL high: one period, SCL low, clear ack enable, stop counter, idle
// R16 - software sets ack data bit before starting the acknowledge sequence
// R17 - stop: SDA low; once low, count period, release SCL, release SDA later
// R18 - SDA high with SCL high sets stop flag; period later clear enable, interrupt
// R19 - released SCL holds counter until SCL reads high, then reloads and counts
// R20 - SCL high time is at least one full baud period despite stretching
// R21 - counter reloads from low seven reload bits, counts to zero, stops
// R22 - counter decrements twice per instruction cycle
// R23 - SDA and SCL only driven low or released; decisions use pin levels
//
// The address map and the AXI4-Lite interface to the registers were decided locally.
`include "i2cm_defs.svh"

module i2cm_engine (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [`I2CM_AW-1:0]  s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [`I2CM_AW-1:0]  s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic                 scl_i,
  output logic                      scl_o,
  output logic                      scl_oe_n,
  input  wire logic                 sda_i,
  output logic                      sda_o,
  output logic                      sda_oe_n
);

  i2cm_pkg::i2cm_state_t st_reg;
  i2cm_pkg::i2cm_status_t stat;
  i2cm_pkg::i2cm_ctl_t   ctl;

  logic        scl_m_reg, scl_s_reg, sda_m_reg, sda_s_reg;
  logic        awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0]  bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic        scl_oe_n_reg, sda_oe_n_reg, pin_o_reg, load_reg;
  logic [3:0]  bitc_reg;
  logic [7:0]  shift_reg, buf_reg;
  logic [6:0]  baud_reg;
  logic        bf_reg, write_collision_flag_reg, ovf_reg, irq_reg, ackst_reg, stop_reg;
  logic        receive_enable_bit_reg, ack_sequence_enable_reg, pen_reg, ack_data_bit_reg;
  logic        to, idle, in_tx, wr_fire, rd_fire, wr_map, rd_map;
  logic        buf_wr, ctl_wr, stat_wr, baud_wr, buf_rd;
  logic        start_tx, go_rx, go_ack, go_stp, ack_level;
  logic        tx_fall, tx_fall8, tx_fall9, rx_done, ack_done, stop_seen, stop_done;
  logic [7:0]  rx_byte;

  // pins pass two flops; only the second stage is ever read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_m_reg <= 1'b1;
      scl_s_reg <= 1'b1;
      sda_m_reg <= 1'b1;
      sda_s_reg <= 1'b1;
    end else begin
      scl_m_reg <= scl_i;
      scl_s_reg <= scl_m_reg;
      sda_m_reg <= sda_i;
      sda_s_reg <= sda_m_reg;
    end
  end

  // axi4-lite: address and data taken together, one of each under way
  assign wr_fire = awready_reg;
  assign rd_fire = arready_reg;
  assign wr_map  = (s_axi_awaddr[`I2CM_AW-1:4] == '0) && (s_axi_awaddr[1:0] == 2'h0);
  assign rd_map  = (s_axi_araddr[`I2CM_AW-1:4] == '0) && (s_axi_araddr[1:0] == 2'h0);
  assign buf_wr  = wr_fire && wr_map && s_axi_wstrb[0] && (s_axi_awaddr[3:0] == `I2CM_OFF_BUF);
  assign ctl_wr  = wr_fire && wr_map && s_axi_wstrb[0] && (s_axi_awaddr[3:0] == `I2CM_OFF_CTL);
  assign stat_wr = wr_fire && wr_map && s_axi_wstrb[0] && (s_axi_awaddr[3:0] == `I2CM_OFF_STAT);
  assign baud_wr = wr_fire && wr_map && s_axi_wstrb[0] && (s_axi_awaddr[3:0] == `I2CM_OFF_BAUD);
  assign buf_rd  = rd_fire && rd_map && (s_axi_araddr[3:0] == `I2CM_OFF_BUF);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `I2CM_RESP_OKAY;
    end else begin
      awready_reg <= s_axi_awvalid && s_axi_wvalid && !awready_reg && !bvalid_reg;
      wready_reg  <= s_axi_awvalid && s_axi_wvalid && !awready_reg && !bvalid_reg;
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_map ? `I2CM_RESP_OKAY : `I2CM_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  assign stat = '{busy: !idle, port_interrupt_flag: irq_reg, receive_overflow_flag: ovf_reg,
                  write_collision_flag: write_collision_flag_reg, ack_status_bit: ackst_reg,
                  stop_detected: stop_reg, buffer_full_flag: bf_reg};
  assign ctl  = '{ack_data_bit: ack_data_bit_reg, ack_sequence_enable: ack_sequence_enable_reg,
                  receive_enable_bit: receive_enable_bit_reg, spare: 2'h0, stop_sequence_enable: pen_reg};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= `I2CM_RESP_OKAY;
      rdata_reg   <= 32'h0000_0000;
    end else begin
      arready_reg <= s_axi_arvalid && !arready_reg && !rvalid_reg;
      if (rd_fire) begin
        rvalid_reg <= 1'b1;
        rresp_reg  <= rd_map ? `I2CM_RESP_OKAY : `I2CM_RESP_SLVERR;
        rdata_reg  <= 32'h0000_0000;
        if (rd_map) begin
          case (s_axi_araddr[3:0])
            `I2CM_OFF_BUF:  rdata_reg <= {24'h00_0000, buf_reg};
            `I2CM_OFF_CTL:  rdata_reg <= {26'h000_0000, ctl};
            `I2CM_OFF_STAT: rdata_reg <= {25'h000_0000, stat};
            `I2CM_OFF_BAUD: rdata_reg <= {25'h000_0000, baud_reg};
            default:        rdata_reg <= 32'h0000_0000;
          endcase
        end
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  i2cm_baud u_baud (
    .aclk    (aclk),
    .aresetn (aresetn),
    .load    (load_reg),
    .reload  (baud_reg),
    .timeout (to)
  );

  assign idle      = (st_reg == i2cm_pkg::S_IDLE);
  assign in_tx     = (st_reg == i2cm_pkg::S_TX_LOW) || (st_reg == i2cm_pkg::S_TX_REL) ||
                     (st_reg == i2cm_pkg::S_TX_HIGH);
  assign start_tx  = buf_wr && idle;
  assign go_stp    = ctl_wr && idle && s_axi_wdata[`I2CM_CTL_PEN];
  assign go_ack    = ctl_wr && idle && s_axi_wdata[`I2CM_CTL_ACK_SEQUENCE_ENABLE] && !go_stp;
  assign go_rx     = ctl_wr && idle && s_axi_wdata[`I2CM_CTL_RECEIVE_ENABLE_BIT] && !go_stp && !go_ack; // R9
  assign ack_level = s_axi_wdata[`I2CM_CTL_ACK_DATA_BIT];
  assign tx_fall   = (st_reg == i2cm_pkg::S_TX_HIGH) && to;
  assign tx_fall8  = tx_fall && (bitc_reg == `I2CM_BIT_LAST);
  assign tx_fall9  = tx_fall && (bitc_reg == `I2CM_BIT_ACK);
  assign rx_done   = (st_reg == i2cm_pkg::S_RX_HIGH) && to && (bitc_reg == `I2CM_BIT_LAST);
  assign rx_byte   = {shift_reg[6:0], sda_s_reg};
  assign ack_done  = (st_reg == i2cm_pkg::S_ACK_HIGH) && to;
  assign stop_seen = (st_reg == i2cm_pkg::S_STP_WAIT) && sda_s_reg && scl_s_reg;
  assign stop_done = (st_reg == i2cm_pkg::S_STP_FIN) && to;

  // bus sequencer; oe_n low pulls the pin low, high lets it float
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg       <= i2cm_pkg::S_IDLE;
      bitc_reg     <= 4'h0;
      shift_reg    <= 8'h00;
      scl_oe_n_reg <= 1'b1;
      sda_oe_n_reg <= 1'b1;
      load_reg     <= 1'b0;
    end else begin
      load_reg <= 1'b0;
      case (st_reg)
        i2cm_pkg::S_IDLE: begin
          if (start_tx) begin
            shift_reg    <= s_axi_wdata[7:0]; // R1
            sda_oe_n_reg <= s_axi_wdata[7]; // R6
            scl_oe_n_reg <= 1'b0;
            bitc_reg     <= 4'h0;
            load_reg     <= 1'b1;
            st_reg       <= i2cm_pkg::S_TX_LOW;
          end else if (go_stp) begin
            sda_oe_n_reg <= 1'b0; // R17
            scl_oe_n_reg <= 1'b0;
            st_reg       <= i2cm_pkg::S_STP_SDA;
          end else if (go_ack) begin
            scl_oe_n_reg <= 1'b0; // R14
            sda_oe_n_reg <= ack_level;
            load_reg     <= 1'b1;
            st_reg       <= i2cm_pkg::S_ACK_LOW;
          end else if (go_rx) begin
            scl_oe_n_reg <= 1'b0;
            sda_oe_n_reg <= 1'b1;
            bitc_reg     <= 4'h0;
            load_reg     <= 1'b1;
            st_reg       <= i2cm_pkg::S_RX_LOW;
          end
        end
        i2cm_pkg::S_TX_LOW: begin
          if (to) begin
            scl_oe_n_reg <= 1'b1; // R2
            st_reg       <= i2cm_pkg::S_TX_REL;
          end
        end
        i2cm_pkg::S_TX_REL: begin
          if (scl_s_reg) begin
            load_reg <= 1'b1; // R19 R20
            st_reg   <= i2cm_pkg::S_TX_HIGH;
          end
        end
        i2cm_pkg::S_TX_HIGH: begin
          if (to) begin
            scl_oe_n_reg <= 1'b0; // R2
            bitc_reg     <= bitc_reg + 4'h1;
            if (bitc_reg == `I2CM_BIT_ACK) begin
              st_reg <= i2cm_pkg::S_IDLE; // R5
            end else if (bitc_reg == `I2CM_BIT_LAST) begin
              sda_oe_n_reg <= 1'b1; // R3
              load_reg     <= 1'b1;
              st_reg       <= i2cm_pkg::S_TX_LOW;
            end else begin
              sda_oe_n_reg <= shift_reg[6]; // R6
              shift_reg    <= {shift_reg[6:0], 1'b0};
              load_reg     <= 1'b1;
              st_reg       <= i2cm_pkg::S_TX_LOW;
            end
          end
        end
        i2cm_pkg::S_RX_LOW: begin
          if (to) begin
            scl_oe_n_reg <= 1'b1; // R10
            st_reg       <= i2cm_pkg::S_RX_REL;
          end
        end
        i2cm_pkg::S_RX_REL: begin
          if (scl_s_reg) begin
            load_reg <= 1'b1; // R19
            st_reg   <= i2cm_pkg::S_RX_HIGH;
          end
        end
        i2cm_pkg::S_RX_HIGH: begin
          if (to) begin
            shift_reg    <= rx_byte; // R10
            scl_oe_n_reg <= 1'b0;
            bitc_reg     <= bitc_reg + 4'h1;
            if (bitc_reg == `I2CM_BIT_LAST) begin
              st_reg <= i2cm_pkg::S_IDLE; // R11
            end else begin
              load_reg <= 1'b1;
              st_reg   <= i2cm_pkg::S_RX_LOW;
            end
          end
        end
        i2cm_pkg::S_ACK_LOW: begin
          if (to) begin
            scl_oe_n_reg <= 1'b1; // R14
            st_reg       <= i2cm_pkg::S_ACK_REL;
          end
        end
        i2cm_pkg::S_ACK_REL: begin
          if (scl_s_reg) begin
            load_reg <= 1'b1; // R15
            st_reg   <= i2cm_pkg::S_ACK_HIGH;
          end
        end
        i2cm_pkg::S_ACK_HIGH: begin
          if (to) begin
            scl_oe_n_reg <= 1'b0; // R15
            st_reg       <= i2cm_pkg::S_IDLE;
          end
        end
        i2cm_pkg::S_STP_SDA: begin
          if (!sda_s_reg) begin
            load_reg <= 1'b1; // R17
            st_reg   <= i2cm_pkg::S_STP_LOW;
          end
        end
        i2cm_pkg::S_STP_LOW: begin
          if (to) begin
            scl_oe_n_reg <= 1'b1; // R17
            st_reg       <= i2cm_pkg::S_STP_REL;
          end
        end
        i2cm_pkg::S_STP_REL: begin
          if (scl_s_reg) begin
            load_reg <= 1'b1; // R19
            st_reg   <= i2cm_pkg::S_STP_HIGH;
          end
        end
        i2cm_pkg::S_STP_HIGH: begin
          if (to) begin
            sda_oe_n_reg <= 1'b1; // R17
            st_reg       <= i2cm_pkg::S_STP_WAIT;
          end
        end
        i2cm_pkg::S_STP_WAIT: begin
          if (stop_seen) begin
            load_reg <= 1'b1; // R18
            st_reg   <= i2cm_pkg::S_STP_FIN;
          end
        end
        i2cm_pkg::S_STP_FIN: begin
          if (to) begin
            st_reg <= i2cm_pkg::S_IDLE; // R18
          end
        end
        default: begin
          scl_oe_n_reg <= 1'b1;
          sda_oe_n_reg <= 1'b1;
          st_reg       <= i2cm_pkg::S_IDLE;
        end
      endcase
    end
  end

  // control register; hardware clears the enables when each sequence ends
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      receive_enable_bit_reg  <= 1'b0;
      ack_sequence_enable_reg <= 1'b0;
      pen_reg   <= 1'b0;
      ack_data_bit_reg <= 1'b0;
      baud_reg  <= `I2CM_BAUD_RST;
    end else begin
      if (ctl_wr) begin
        ack_data_bit_reg <= s_axi_wdata[`I2CM_CTL_ACK_DATA_BIT];
      end
      if (baud_wr) begin
        baud_reg <= s_axi_wdata[6:0]; // R21
      end
      if (go_rx) begin
        receive_enable_bit_reg <= 1'b1;
      end else if (rx_done) begin
        receive_enable_bit_reg <= 1'b0; // R11
      end
      if (go_ack) begin
        ack_sequence_enable_reg <= 1'b1;
      end else if (ack_done) begin
        ack_sequence_enable_reg <= 1'b0; // R15
      end
      if (go_stp) begin
        pen_reg <= 1'b1;
      end else if (stop_done) begin
        pen_reg <= 1'b0; // R18
      end
    end
  end

  // status flags; a hardware set beats a software clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buf_reg   <= 8'h00;
      bf_reg    <= 1'b0;
      write_collision_flag_reg  <= 1'b0;
      ovf_reg   <= 1'b0;
      irq_reg   <= 1'b0;
      ackst_reg <= 1'b0;
      stop_reg  <= 1'b0;
    end else begin
      if (start_tx) begin
        buf_reg <= s_axi_wdata[7:0]; // R1
      end else if (rx_done && !bf_reg) begin
        buf_reg <= rx_byte; // R11
      end
      if (start_tx || rx_done) begin
        bf_reg <= 1'b1; // R1
      end else if (tx_fall8 || (buf_rd && !in_tx)) begin
        bf_reg <= 1'b0; // R3 R12
      end
      if (buf_wr && !idle) begin
        write_collision_flag_reg <= 1'b1; // R7 R8
      end else if (stat_wr && s_axi_wdata[`I2CM_ST_WRITE_COLLISION_FLAG]) begin
        write_collision_flag_reg <= 1'b0;
      end
      if (rx_done && bf_reg) begin
        ovf_reg <= 1'b1; // R13
      end else if (stat_wr && s_axi_wdata[`I2CM_ST_OVF]) begin
        ovf_reg <= 1'b0;
      end
      if (tx_fall9 || rx_done || stop_done) begin
        irq_reg <= 1'b1; // R5 R11 R18
      end else if (stat_wr && s_axi_wdata[`I2CM_ST_IRQ]) begin
        irq_reg <= 1'b0;
      end
      if (tx_fall9) begin
        ackst_reg <= sda_s_reg; // R4
      end
      if (stop_seen) begin
        stop_reg <= 1'b1; // R18
      end else if (start_tx || (stat_wr && s_axi_wdata[`I2CM_ST_STOP])) begin
        stop_reg <= 1'b0;
      end
    end
  end

  // open-drain pads: the data value is a constant low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_o_reg <= 1'b0;
    end else begin
      pin_o_reg <= 1'b0; // R23
    end
  end

  assign scl_o         = pin_o_reg;
  assign sda_o         = pin_o_reg;
  assign scl_oe_n      = scl_oe_n_reg;
  assign sda_oe_n      = sda_oe_n_reg;
  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_tx_start: assert property (start_tx |=> bf_reg && !scl_oe_n && st_reg == i2cm_pkg::S_TX_LOW ##1 load_reg == 1'b0) // R1
    else $error("buffer write did not start a transfer");
  a_tx_scl_low: assert property (st_reg == i2cm_pkg::S_TX_LOW |-> !scl_oe_n) // R2
    else $error("scl not held low in low phase");
  a_bf_eighth: assert property (tx_fall8 && !start_tx |=> !bf_reg && sda_oe_n) // R3
    else $error("eighth fall did not clear full and free sda");
  a_ack_capture: assert property (tx_fall9 |=> ackst_reg == $past(sda_s_reg) && irq_reg && idle && !scl_oe_n) // R4
    else $error("acknowledge not captured at ninth fall");
  a_write_collision_flag_drop: assert property (buf_wr && !idle |=> write_collision_flag_reg && buf_reg == $past(buf_reg)) // R7
    else $error("colliding write not flagged or not dropped");
  a_receive_enable_bit_ignore: assert property (ctl_wr && !idle && !receive_enable_bit_reg |=> !receive_enable_bit_reg) // R9
    else $error("receive enable taken while busy");
  a_rx_finish: assert property (rx_done |=> !receive_enable_bit_reg && bf_reg && irq_reg && idle && !scl_oe_n) // R11
    else $error("receive end sequence wrong");
  a_overflow: assert property (rx_done && bf_reg |=> ovf_reg && buf_reg == $past(buf_reg)) // R13
    else $error("overflow not flagged");
  a_release_hold: assert property (st_reg == i2cm_pkg::S_TX_REL && !scl_s_reg |=> st_reg == i2cm_pkg::S_TX_REL) // R19
    else $error("counter resumed before scl high");
  a_high_release: assert property ((st_reg == i2cm_pkg::S_TX_HIGH || st_reg == i2cm_pkg::S_RX_HIGH) |-> scl_oe_n) // R20
    else $error("scl pulled low during high period");
  a_stop_flag: assert property (stop_seen |=> stop_reg && pen_reg && st_reg == i2cm_pkg::S_STP_FIN) // R18
    else $error("stop not flagged");
  a_pins_low: assert property (!scl_o && !sda_o) // R23
    else $error("pad driven high");

  c_tx_byte: cover property (tx_fall9);
  c_rx_byte: cover property (rx_done);
  c_ack_seq: cover property (ack_done);
  c_stop_seq: cover property (stop_done);

endmodule

// >>> hw/i2cm_pkg.sv
package i2cm_pkg;

  typedef enum logic [3:0] {
    S_IDLE, S_TX_LOW, S_TX_REL, S_TX_HIGH,
    S_RX_LOW, S_RX_REL, S_RX_HIGH,
    S_ACK_LOW, S_ACK_REL, S_ACK_HIGH,
    S_STP_SDA, S_STP_LOW, S_STP_REL, S_STP_HIGH, S_STP_WAIT, S_STP_FIN
  } i2cm_state_t;

  // field order matches the status bit positions, bit 6 down to bit 0
  typedef struct packed {
    logic busy;
    logic port_interrupt_flag;
    logic receive_overflow_flag;
    logic write_collision_flag;
    logic ack_status_bit;
    logic stop_detected;
    logic buffer_full_flag;
  } i2cm_status_t;

  typedef struct packed {
    logic       ack_data_bit;
    logic       ack_sequence_enable;
    logic       receive_enable_bit;
    logic [1:0] spare;
    logic       stop_sequence_enable;
  } i2cm_ctl_t;

endpackage

// >>> sim/i2cm_engine_tb.sv
module i2cm_engine_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, awv, wv, bq, arv, rq, awr, wr_r, bv, arr, rv, so, dO, soe, doe;
  logic        rxm, nk, st, sp, dp;
  logic [5:0]  aw, ar;
  logic [31:0] wd, rdt, d;
  logic [1:0]  br, rr, r;
  logic [7:0]  txb, got, b, b1;
  int          err_total, checked, cyc;
  wire         scl = soe & ~sp;
  wire         sda = doe & ~dp;
  i2cm_engine i2cm_engine_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_r),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bq), .s_axi_araddr(ar), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rq),
    .scl_i(scl), .scl_o(so), .scl_oe_n(soe), .sda_i(sda), .sda_o(dO), .sda_oe_n(doe));
  i2cm_slave i2cm_slave_inst (.scl(scl), .sda(sda), .start(st), .rx_mode(rxm), .nack(nk), .stretch(1'b1),
    .tx_byte(txb), .scl_pull(sp), .sda_pull(dp), .got(got));
  initial begin
    aclk = 0;
    forever #10 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    @(posedge aclk);
    aw <= a;
    wd <= v;
    awv <= 1;
    wv <= 1;
    bq <= 1;
    do begin
      @(posedge aclk);
      if (awr === 1'b1) awv <= 0;
      if (wr_r === 1'b1) wv <= 0;
    end while (bv !== 1'b1);
    r = br;
    bq <= 0;
  endtask
  task automatic rd(input logic [5:0] a);
    @(posedge aclk);
    ar <= a;
    arv <= 1;
    rq <= 1;
    do begin
      @(posedge aclk);
      if (arr === 1'b1) arv <= 0;
    end while (rv !== 1'b1);
    d = rdt;
    r = rr;
    rq <= 0;
  endtask
  task automatic idle();
    do rd(6'h08); while (d[6] !== 1'b0);
  endtask
  task automatic kick(input logic x, input logic n, input logic [7:0] t);
    rxm <= x;
    nk <= n;
    txb <= t;
    @(posedge aclk);
    st <= 1;
    @(posedge aclk);
    st <= 0;
  endtask
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      err_total++;
      tally_and_finish();
    end
  end
  initial begin
    {aresetn, awv, wv, bq, arv, rq, rxm, nk, st, aw, ar, wd, txb} = 0;
    void'($urandom(79));
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    rd(6'h08);
    chk(d, 32'h0);
    rd(6'h0c);
    chk(d, 32'h9);
    rd(6'h10);
    chk({30'h0, r}, 32'h2);
    wr(6'h0c, 32'h3);
    chk({30'h0, r}, 32'h0);
    $display("test regs done");
    for (int k = 0; k < 2; k++) begin
      b = 8'($urandom);
      kick(0, k == 0, 0);
      wr(6'h00, {24'h0, b});
      rd(6'h08);
      chk(d, (k == 0) ? 32'h41 : 32'h45);
      wr(6'h00, {24'h0, ~b});
      wr(6'h04, 32'h8);
      idle();
      chk(d, (k == 0) ? 32'h2c : 32'h28);
      chk({24'h0, got}, {24'h0, b});
      chk({31'h0, scl}, 32'h0);
      rd(6'h04);
      chk(d, 32'h0);
      wr(6'h08, 32'h3a);
      $display("test tx %0d done", k);
    end
    for (int k = 0; k < 2; k++) begin
      b = 8'($urandom);
      if (k == 0) b1 = b;
      kick(1, 0, b);
      wr(6'h04, 32'h8);
      if (k == 1) wr(6'h00, 32'h0);
      idle();
      chk(d, (k == 0) ? 32'h21 : 32'h39);
    end
    rd(6'h00);
    chk(d, {24'h0, b1});
    rd(6'h08);
    chk(d, 32'h38);
    wr(6'h08, 32'h3a);
    $display("test rx done");
    b = 8'($urandom);
    kick(0, 1, 0);
    wr(6'h04, {26'h0, b[0], 5'h10});
    idle();
    chk({31'h0, sda}, {31'h0, b[0]});
    chk({31'h0, scl}, 32'h0);
    rd(6'h04);
    chk(d, {26'h0, b[0], 5'h0});
    wr(6'h04, 32'h1);
    idle();
    chk(d, 32'h22);
    chk({30'h0, scl, sda}, 32'h3);
    chk({30'h0, so, dO}, 32'h0);
    $display("test ack stop done");
    tally_and_finish();
  end
endmodule

// >>> sim/i2cm_slave.sv
module i2cm_slave (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       start,
  input  wire logic       rx_mode,
  input  wire logic       nack,
  input  wire logic       stretch,
  input  wire logic [7:0] tx_byte,
  output logic            scl_pull,
  output logic            sda_pull,
  output logic [7:0]      got
);
  timeunit 1ns;
  timeprecision 1ps;
  int n;
  initial begin
    n = 9;
    scl_pull = 0;
    sda_pull = 0;
    got = 0;
  end
  // first read bit must sit on sda before the first rise
  // an idle-high scl gives one extra fall when the master first pulls it low
  always @(posedge start) begin
    n = scl ? -1 : 0;
    sda_pull = rx_mode & ~tx_byte[7];
  end
  always @(posedge scl) if (n < 8) got = {got[6:0], sda};
  always @(negedge scl) begin
    n = n + 1;
    if (rx_mode) sda_pull = (n < 8) ? ~tx_byte[7-n] : 1'b0;
    else sda_pull = (n == 8) & ~nack;
    // stretch every low phase so the master must wait for scl
    if (stretch) begin
      scl_pull = 1;
      #300;
      scl_pull = 0;
    end
  end
endmodule
